// *** core/pma_core.v ***
// proximity measurement sequencer, threshold alert and i2c register access
`timescale 1ns/1ps
`include "pma_defs.vh"
module pma_core #(
  parameter [6:0]  DEV_ADDR      = `PMA_I2C_ADDR,
  parameter [15:0] QUARTER_CYC   = `PMA_QUARTER_CYC,
  parameter [7:0]  GAP_QUARTERS  = `PMA_GAP_QUARTERS
) (
  input  wire        clock_in,
  input  wire        rstn_in,
  input  wire        scl_in,
  input  wire        sda_in,
  input  wire [15:0] prox_sample_in,
  output wire        sda_out,
  output wire        sda_oe_n_out,
  output wire        alert_out,
  output reg         alert_oe_n_out,
  output reg         emitter_on_out,
  output reg         ambient_kill_out,
  output reg         busy_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  reg  [1:0] scl_sync;
  reg  [1:0] sda_sync;
  reg        scl_d;
  reg        sda_d;
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end
  wire scl_s     = scl_sync[1];
  wire sda_s     = sda_sync[1];
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // register file
  // ****************************************
  reg  [15:0] conf1;
  reg  [15:0] conf3;
  reg  [15:0] cancel;
  reg  [15:0] thr_low;
  reg  [15:0] thr_high;
  reg  [15:0] result;
  reg  [1:0]  flags;
  reg         trig_pend;
  // write strobe from the serial side
  reg         wr_stb;
  reg  [7:0]  cmd;
  reg  [15:0] wr_data;

  // readback decode, used for both bytes of a read
  function [15:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `PMA_REG_CONF1:    rd_mux = conf1;
        `PMA_REG_CONF3:    rd_mux = {conf3[15:3], trig_pend, conf3[1:0]};
        `PMA_REG_CANCEL:   rd_mux = cancel;
        `PMA_REG_THR_LOW:  rd_mux = thr_low;
        `PMA_REG_THR_HIGH: rd_mux = thr_high;
        `PMA_REG_RESULT:   rd_mux = result;
        `PMA_REG_FLAGS:    rd_mux = {6'h00, flags, 8'h00};
        default:           rd_mux = 16'h0000;
      endcase
    end
  endfunction

  // integration time in quarter units: 1T..4T in half steps, then 8T
  function [7:0] it_quarters;
    input [2:0] code;
    begin
      case (code)
        3'h7:    it_quarters = 8'h20;
        default: it_quarters = {4'h0, code, 1'b0} + 8'h04;
      endcase
    end
  endfunction

  // ****************************************
  // i2c slave
  // ****************************************
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WDAT = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RDAT = 3'h5;
  localparam S_RACK = 3'h6;
  reg  [2:0] st;
  reg  [3:0] bitc;
  reg  [7:0] shreg;
  reg  [7:0] tx;
  reg  [1:0] byte_idx;
  reg        rd_hi;
  reg        rw;
  wire [15:0] rd_word = rd_mux(cmd);

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      st <= S_IDLE;
      bitc <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'hff;
      byte_idx <= 2'h0;
      rd_hi <= 1'b0;
      rw <= 1'b0;
      cmd <= 8'h00;
      wr_data <= 16'h0000;
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        st <= S_ADDR;
        bitc <= 4'h0;
        byte_idx <= 2'h0;
        rd_hi <= 1'b0;
      end else if (bus_stop) begin
        st <= S_IDLE;
      end else if (scl_rise) begin
        if (st == S_ADDR || st == S_WDAT) begin
          shreg <= {shreg[6:0], sda_s};
          bitc <= bitc + 4'h1;
        end else if (st == S_RACK && sda_s) begin
          st <= S_IDLE; // master nack ends the read
        end
      end else if (scl_fall) begin
        case (st)
          S_ADDR: if (bitc == 4'h8) begin
            if (shreg[7:1] == DEV_ADDR) begin
              st <= S_AACK;
              rw <= shreg[0];
            end else begin
              st <= S_IDLE;
            end
          end
          S_AACK: begin
            bitc <= 4'h0;
            if (rw) begin
              tx <= rd_word[7:0];
              rd_hi <= 1'b1;
              st <= S_RDAT;
            end else begin
              st <= S_WDAT;
            end
          end
          S_WDAT: if (bitc == 4'h8) begin
            // byte order: command code, low byte, high byte
            if (byte_idx == 2'h0) begin
              cmd <= shreg;
            end else if (byte_idx == 2'h1) begin
              wr_data[7:0] <= shreg;
            end else begin
              wr_data[15:8] <= shreg;
              wr_stb <= 1'b1;
            end
            byte_idx <= (byte_idx == 2'h2) ? 2'h1 : byte_idx + 2'h1;
            st <= S_WACK;
          end
          S_WACK: begin
            bitc <= 4'h0;
            st <= S_WDAT;
          end
          S_RDAT: begin
            if (bitc == 4'h7) begin
              st <= S_RACK;
            end else begin
              tx <= {tx[6:0], 1'b1};
              bitc <= bitc + 4'h1;
            end
          end
          S_RACK: begin
            bitc <= 4'h0;
            tx <= rd_hi ? rd_word[15:8] : rd_word[7:0];
            rd_hi <= ~rd_hi;
            st <= S_RDAT;
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end
  // open drain data: only ever pulled low
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~((st == S_AACK) | (st == S_WACK) | ((st == S_RDAT) & ~tx[7]));

  // ****************************************
  // measurement sequencer
  // ****************************************
  localparam M_IDLE = 3'h0;
  localparam M_TRIG = 3'h1;
  localparam M_AMB  = 3'h2;
  localparam M_MEAS = 3'h3;
  localparam M_SHUT = 3'h4;
  localparam M_GAP  = 3'h5;
  reg  [2:0]  mst;
  reg  [15:0] pre;
  reg  [7:0]  qcnt;
  reg  [7:0]  plen;
  wire [7:0]  itq      = it_quarters(conf1[`PMA_C1_IT_LSB+2:`PMA_C1_IT_LSB]);
  wire        forced   = conf3[`PMA_C3_FORCED];
  wire        active   = ~conf1[`PMA_C1_SHUTDOWN];
  wire        qtick    = (pre == QUARTER_CYC - 16'h1);
  wire        phase_end = qtick && (qcnt == plen - 8'h1);
  wire        meas_done = (mst == M_MEAS) && phase_end;
  wire        start_ok  = active && (forced ? trig_pend : 1'b1);

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      mst <= M_IDLE;
      pre <= 16'h0000;
      qcnt <= 8'h00;
      plen <= 8'h00;
    end else begin
      pre <= (mst == M_IDLE || qtick) ? 16'h0000 : pre + 16'h1;
      if (qtick) begin
        qcnt <= phase_end ? 8'h00 : qcnt + 8'h01;
      end
      case (mst)
        M_IDLE: if (start_ok) begin
          mst <= M_TRIG;
          qcnt <= 8'h00;
          plen <= {1'b0, itq[7:1]};
        end
        M_TRIG: if (phase_end) begin
          mst <= M_AMB;
          plen <= itq + {itq[6:0], 1'b0};
        end
        M_AMB: if (phase_end) begin
          mst <= M_MEAS;
          plen <= itq;
        end
        M_MEAS: if (phase_end) begin
          mst <= M_SHUT;
        end
        // forced mode stops after one cycle, auto mode waits out the duty gap
        M_SHUT: if (phase_end) begin
          mst <= forced ? M_IDLE : M_GAP;
          plen <= GAP_QUARTERS;
        end
        M_GAP: if (phase_end || !active || forced) begin
          mst <= M_IDLE;
        end
        default: mst <= M_IDLE;
      endcase
    end
  end

  // ****************************************
  // registers, threshold persistence and alert
  // ****************************************
  wire [15:0] corrected = (prox_sample_in > cancel) ? prox_sample_in - cancel : 16'h0000;
  wire        above     = corrected > thr_high;
  wire        below     = corrected < thr_low;
  wire [2:0]  pers      = {1'b0, conf1[`PMA_C1_PERS_LSB+1:`PMA_C1_PERS_LSB]} + 3'h1;
  reg  [2:0]  hi_cnt;
  reg  [2:0]  lo_cnt;
  reg         logic_lvl;
  wire        hi_hit    = meas_done && above && (hi_cnt + 3'h1 >= pers);
  wire        lo_hit    = meas_done && below && (lo_cnt + 3'h1 >= pers);
  wire        flag_wr   = wr_stb && (cmd == `PMA_REG_FLAGS);
  wire [1:0]  flag_clr  = flag_wr ? wr_data[`PMA_FLAG_HIGH:`PMA_FLAG_LOW] : 2'h0;
  wire        logic_sel = conf3[`PMA_C3_LOGIC_SEL];

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      conf1 <= `PMA_CONF1_RST;
      conf3 <= `PMA_CONF3_RST;
      cancel <= 16'h0000;
      thr_low <= `PMA_THR_RST;
      thr_high <= `PMA_THR_RST;
      result <= 16'h0000;
      flags <= 2'h0;
      trig_pend <= 1'b0;
      hi_cnt <= 3'h0;
      lo_cnt <= 3'h0;
      logic_lvl <= 1'b0;
      alert_oe_n_out <= 1'b1;
      emitter_on_out <= 1'b0;
      ambient_kill_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      if (wr_stb) begin
        case (cmd)
          `PMA_REG_CONF1:    conf1 <= wr_data;
          `PMA_REG_CONF3:    conf3 <= wr_data;
          `PMA_REG_CANCEL:   cancel <= wr_data;
          `PMA_REG_THR_LOW:  thr_low <= wr_data;
          `PMA_REG_THR_HIGH: thr_high <= wr_data;
          default:           conf1 <= conf1;
        endcase
      end
      // one cycle per written one, cleared at start
      if (wr_stb && cmd == `PMA_REG_CONF3 && wr_data[`PMA_C3_TRIGGER] &&
          wr_data[`PMA_C3_FORCED]) begin
        trig_pend <= 1'b1;
      end else if (mst == M_IDLE && start_ok && forced) begin
        trig_pend <= 1'b0;
      end
      if (meas_done) begin
        result <= corrected;
      end
      if (meas_done) begin
        hi_cnt <= above ? ((hi_cnt < 3'h4) ? hi_cnt + 3'h1 : hi_cnt) : 3'h0;
        lo_cnt <= below ? ((lo_cnt < 3'h4) ? lo_cnt + 3'h1 : lo_cnt) : 3'h0;
      end
      // write one clears only that flag
      flags <= (flags & ~flag_clr) | {hi_hit, lo_hit};
      if (hi_hit) begin
        logic_lvl <= 1'b1;
      end else if (lo_hit) begin
        logic_lvl <= 1'b0;
      end
      // normal mode alert while any flag
      alert_oe_n_out <= logic_sel ? ~(hi_hit | (logic_lvl & ~lo_hit))
                                  : ~(|((flags & ~flag_clr) | {hi_hit, lo_hit}));
      emitter_on_out <= (mst == M_AMB) || (mst == M_MEAS);
      ambient_kill_out <= (mst == M_AMB);
      busy_out <= (mst != M_IDLE) && (mst != M_GAP);
    end
  end
  // alert never drives high
  assign alert_out = 1'b0;
endmodule

// *** core/pma_defs.vh ***
// register offsets, field positions and timing constants of the proximity block
`ifndef PMA_DEFS_VH
`define PMA_DEFS_VH
// ****************************************
// register command codes
// ****************************************
`define PMA_REG_CONF1      8'h03
`define PMA_REG_CONF3      8'h04
`define PMA_REG_CANCEL     8'h05
`define PMA_REG_THR_LOW    8'h06
`define PMA_REG_THR_HIGH   8'h07
`define PMA_REG_RESULT     8'h08
`define PMA_REG_FLAGS      8'h0b
// ****************************************
// field positions
// ****************************************
`define PMA_C1_SHUTDOWN    0
`define PMA_C1_IT_LSB      1
`define PMA_C1_PERS_LSB    4
`define PMA_C3_LOGIC_SEL   1
`define PMA_C3_TRIGGER     2
`define PMA_C3_FORCED      3
`define PMA_FLAG_LOW       8
`define PMA_FLAG_HIGH      9
// ****************************************
// reset values
// ****************************************
`define PMA_CONF1_RST      16'h0001
`define PMA_CONF3_RST      16'h0000
`define PMA_THR_RST        16'h0000
`define PMA_I2C_ADDR       7'h2a
// ****************************************
// timing: base unit is a quarter of 1T (1T = 50 us)
// ****************************************
`define PMA_QUARTER_NS     12500
`define PMA_CLK_NS         5
`define PMA_QUARTER_CYC    (`PMA_QUARTER_NS / `PMA_CLK_NS)
`define PMA_GAP_QUARTERS   160
`endif

// *** verification/pma_core_chk.sv ***
// assertion checker for the sequencer and alert pins
`timescale 1ns/1ps
module pma_core_chk (
  input wire clock_in,
  input wire rstn_in,
  input wire alert_out,
  input wire alert_oe_n_out,
  input wire emitter_on_out,
  input wire ambient_kill_out,
  input wire busy_out
);
  // ****
  // phase counters
  // ****
  reg [15:0] n_t, n_a, n_m, n_s;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ratios, not lengths, so any code and quarter size fits
  always @(posedge clock_in) begin
    if (!rstn_in || !busy_out) begin
      n_t <= 16'h0000;
      n_a <= 16'h0000;
      n_m <= 16'h0000;
      n_s <= 16'h0000;
    end else if (ambient_kill_out) begin
      n_a <= n_a + 16'h0001;
    end else if (emitter_on_out) begin
      n_m <= n_m + 16'h0001;
    end else if (n_a == 16'h0000) begin
      n_t <= n_t + 16'h0001;
    end else begin
      n_s <= n_s + 16'h0001;
    end
  end
  a_alert_never_high: assert property (alert_out == 1'b0)
    else $error("alert pin driven high");
  a_emit_in_busy: assert property (emitter_on_out |-> busy_out)
    else $error("emitter on outside a cycle");
  a_amb_with_emit: assert property (ambient_kill_out |-> emitter_on_out)
    else $error("ambient removal without emitter");
  a_amb_before_meas: assert property ($rose(emitter_on_out) |-> ambient_kill_out)
    else $error("measure not led by ambient removal");
  a_amb_three_it: assert property ($fell(emitter_on_out) |-> n_a == 16'd3 * n_m)
    else $error("ambient phase not three times measure");
  a_trig_half_it: assert property ($fell(emitter_on_out) |-> n_m == 16'd2 * n_t)
    else $error("trigger delay not half of measure");
  a_shut_one_it: assert property ($fell(busy_out) |-> n_s == n_m)
    else $error("shutdown phase length wrong");
  // alert lands in the last emitter clock, one clock before the emitter pin drops
  a_alert_after_meas: assert property (
    $fell(alert_oe_n_out) |-> (busy_out && emitter_on_out) ##1 (busy_out && !emitter_on_out))
    else $error("alert set outside measure end");
  c_cycle_done: cover property ($fell(busy_out));
  c_alert_set: cover property ($fell(alert_oe_n_out));
  c_alert_free: cover property ($rose(alert_oe_n_out));
endmodule

// *** verification/pma_host.sv ***
// i2c host model standing in for the microcontroller
`timescale 1ns/1ps
`include "pma_defs.vh"
module pma_host #(
  parameter [6:0] ADDR = `PMA_I2C_ADDR
) (
  input  wire clock_in,
  input  wire sda_line_in,
  output reg  scl_out,
  output reg  sda_oe_n_out
);
  // ****
  // bus cycles, scl period of 16 clocks
  // ****
  reg [8:0] r;
  integer   k;
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task q;
    repeat (4) @(posedge clock_in);
  endtask
  // data moves mid-low so it never races the clock edge
  task bit_io(input reg b, output reg v);
    begin
      scl_out <= 1'b0;
      q;
      sda_oe_n_out <= b;
      q;
      scl_out <= 1'b1;
      q;
      v = sda_line_in;
      q;
    end
  endtask
  // byte plus acknowledge bit
  task byte_io(input [8:0] d);
    for (k = 8; k >= 0; k = k - 1) bit_io(d[k], r[k]);
  endtask
  task edge2(input reg a, input reg b);
    begin
      scl_out <= 1'b0;
      q;
      sda_oe_n_out <= a;
      q;
      scl_out <= 1'b1;
      q;
      sda_oe_n_out <= b;
      q;
    end
  endtask
  task wr(input [7:0] c, input [15:0] v);
    begin
      edge2(1'b1, 1'b0);
      byte_io({ADDR, 2'b01});
      byte_io({c, 1'b1});
      byte_io({v[7:0], 1'b1});
      byte_io({v[15:8], 1'b1});
      edge2(1'b0, 1'b1);
    end
  endtask
  task rd(input [7:0] c, output [15:0] v);
    begin
      edge2(1'b1, 1'b0);
      byte_io({ADDR, 2'b01});
      byte_io({c, 1'b1});
      edge2(1'b1, 1'b0);
      byte_io({ADDR, 2'b11});
      byte_io(9'h1fe);
      v[7:0] = r[8:1];
      byte_io(9'h1ff);
      v[15:8] = r[8:1];
      edge2(1'b0, 1'b1);
    end
  endtask
endmodule

// *** verification/proximity_measure_and_alert_bench.sv ***
// self-checking bench of the proximity block
`timescale 1ns/1ps
`include "pma_defs.vh"
module proximity_measure_and_alert_bench;
  // ****
  // wiring
  // ****
  reg         clock_in, rstn_in;
  reg  [15:0] prox_sample_in, mode, rv;
  integer     n_errors, total_checks, cyc, bcnt, blen, i, j;
  wire        scl, h_oe_n, sda_out, sda_oe_n_out, alert_out, alert_oe_n_out, emit, amb, busy_out;
  // pull-ups on both open-drain lines
  wire        sda = (sda_oe_n_out | sda_out) & h_oe_n;
  wire [15:0] al = {15'h0000, alert_oe_n_out | alert_out};
  pma_core #(.QUARTER_CYC(16'd4), .GAP_QUARTERS(8'd2)) DUT (
    .clock_in(clock_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
    .prox_sample_in(prox_sample_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out), .emitter_on_out(emit),
    .ambient_kill_out(amb), .busy_out(busy_out));
  pma_host host (.clock_in(clock_in), .sda_line_in(sda), .scl_out(scl), .sda_oe_n_out(h_oe_n));
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // busy length of the last cycle, and hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (busy_out) bcnt <= bcnt + 1;
    else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
    end
    if (cyc == 90000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one forced cycle, waits for its end
  task meas(input [15:0] s);
    begin
      @(posedge clock_in);
      prox_sample_in <= s;
      host.wr(`PMA_REG_CONF3, mode | 16'h0004);
      for (i = 0; i < 800 && busy_out !== 1'b0; i = i + 1) @(posedge clock_in);
      @(posedge clock_in);
      // a cycle that never ends counts as a mismatch here
      chk("busy", 16'h0000, {15'h0000, busy_out});
    end
  endtask
  task t_reset;
    begin
      host.rd(`PMA_REG_CONF1, rv);
      chk("conf1", `PMA_CONF1_RST, rv);
      host.rd(`PMA_REG_FLAGS, rv);
      chk("flags", 16'h0000, rv);
      host.rd(8'h0c, rv);
      chk("unmapped", 16'h0000, rv);
      host.wr(`PMA_REG_CONF3, mode);
      host.wr(`PMA_REG_THR_LOW, 16'h0010);
      host.wr(`PMA_REG_THR_HIGH, 16'h0100);
    end
  endtask
  // every integration code: busy = 22 quarters of IT/4
  task t_phases;
    begin
      for (j = 0; j < 8; j = j + 1) begin
        host.wr(`PMA_REG_CONF1, {12'h000, j[2:0], 1'b0});
        meas(16'h0050);
        chk("busylen", (j == 7) ? 16'd704 : 16'd88 + 16'd44 * j[15:0], blen[15:0]);
      end
      host.wr(`PMA_REG_CONF1, 16'h0000);
      host.rd(`PMA_REG_CONF3, rv);
      chk("trigger", 16'h0008, rv);
      host.wr(`PMA_REG_RESULT, 16'hffff);
      host.rd(`PMA_REG_RESULT, rv);
      chk("result", 16'h0050, rv);
    end
  endtask
  task t_event;
    begin
      meas(16'h0200);
      host.rd(`PMA_REG_FLAGS, rv);
      chk("flags", 16'h0200, rv);
      meas(16'h0050);
      chk("alert", 16'h0000, al);
      host.wr(`PMA_REG_FLAGS, 16'h0200);
      chk("alert", 16'h0001, al);
      meas(16'h0100);
      meas(16'h0010);
      host.rd(`PMA_REG_FLAGS, rv);
      chk("flags", 16'h0000, rv);
      meas(16'h0005);
      host.rd(`PMA_REG_FLAGS, rv);
      chk("flags", 16'h0100, rv);
      host.wr(`PMA_REG_FLAGS, 16'h0100);
      host.wr(`PMA_REG_CANCEL, 16'h0040);
      meas(16'h0060);
      host.rd(`PMA_REG_RESULT, rv);
      chk("result", 16'h0020, rv);
      host.wr(`PMA_REG_CANCEL, 16'h0000);
    end
  endtask
  // three hits needed; the in-range sample restarts the run
  task t_persist;
    begin
      host.wr(`PMA_REG_CONF1, 16'h0020);
      for (j = 0; j < 6; j = j + 1) begin
        meas((j == 2) ? 16'h0050 : 16'h0200);
        chk("alert", (j == 5) ? 16'h0000 : 16'h0001, al);
      end
      host.wr(`PMA_REG_CONF1, 16'h0000);
      host.wr(`PMA_REG_FLAGS, 16'h0300);
    end
  endtask
  // a low hit first, so logic mode starts released and the upper hit shows
  task t_logic;
    begin
      meas(16'h0005);
      host.wr(`PMA_REG_FLAGS, 16'h0100);
      mode = 16'h000a;
      host.wr(`PMA_REG_CONF3, mode);
      chk("alert", 16'h0001, al);
      meas(16'h0200);
      chk("alert", 16'h0000, al);
      meas(16'h0050);
      chk("alert", 16'h0000, al);
      meas(16'h0005);
      chk("alert", 16'h0001, al);
    end
  endtask
  // auto mode repeats cycles by itself until shut down
  task t_auto;
    begin
      host.wr(`PMA_REG_FLAGS, 16'h0300);
      mode = 16'h0000;
      host.wr(`PMA_REG_CONF3, mode);
      for (i = 0; i < 400 && busy_out !== 1'b0; i = i + 1) @(posedge clock_in);
      for (i = 0; i < 400 && busy_out !== 1'b1; i = i + 1) @(posedge clock_in);
      chk("restart", 16'h0001, {15'h0000, busy_out});
      for (i = 0; i < 400 && busy_out !== 1'b0; i = i + 1) @(posedge clock_in);
      @(posedge clock_in);
      chk("busylen", 16'd88, blen[15:0]);
      host.wr(`PMA_REG_CONF1, 16'h0001);
      repeat (200) @(posedge clock_in);
      chk("busy", 16'h0000, {15'h0000, busy_out});
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && total_checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  initial begin
    n_errors = 0;
    total_checks = 0;
    cyc = 0;
    bcnt = 0;
    blen = 0;
    rstn_in = 1'b0;
    prox_sample_in = 16'h0000;
    mode = 16'h0008;
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    t_reset;
    t_phases;
    t_event;
    t_persist;
    t_logic;
    t_auto;
    end_sim;
  end
endmodule
bind pma_core pma_core_chk chk_i (.clock_in(clock_in), .rstn_in(rstn_in),
  .alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out), .emitter_on_out(emitter_on_out),
  .ambient_kill_out(ambient_kill_out), .busy_out(busy_out));
